// ---- common/ddsr_pkg.sv ----
// package of addresses, field positions, byte lengths and states for the dds register bank
package ddsr_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [4:0] ADDR_CTRL_ONE   = 5'h00;
  localparam logic [4:0] ADDR_UNUSED_A   = 5'h05;
  localparam logic [4:0] ADDR_UNUSED_B   = 5'h06;
  localparam logic [4:0] ADDR_PROF_FIRST = 5'h0e;
  localparam logic [4:0] ADDR_PROF_SIX   = 5'h14;
  localparam logic [4:0] ADDR_PROF_SEVEN = 5'h15;
  localparam logic [4:0] ADDR_WAVE_WORD  = 5'h16;
  localparam logic [4:0] ADDR_LAST       = 5'h16;
  localparam int         NUM_SLOTS       = 23;

  // ****************************************************************
  // byte depth of each register
  // ****************************************************************
  localparam logic [3:0] PROF_BYTES  = 4'h8;
  localparam logic [3:0] WAVE_BYTES  = 4'h4;
  localparam logic [3:0] CTRL_BYTES  = 4'h4;
  localparam logic [3:0] OTHER_BYTES = 4'h4;
  localparam logic [3:0] NO_BYTES    = 4'h0;
  localparam logic [63:0] REG_RESET  = 64'h0;

  // ****************************************************************
  // serial instruction byte
  // ****************************************************************
  localparam int INSTR_READ_BIT = 7;
  localparam logic [6:0] INSTR_LAST_BIT = 7'h07;

  // ****************************************************************
  // control function one fields
  // ****************************************************************
  localparam int RAM_EN_BIT  = 31;
  localparam int INT_PROF_HI = 20;
  localparam int INT_PROF_LO = 17;

  // ****************************************************************
  // profile word fields, bit 0 is the lsb
  // ****************************************************************
  localparam int ASF_HI   = 61;
  localparam int ASF_LO   = 48;
  localparam int POW_HI   = 47;
  localparam int POW_LO   = 32;
  localparam int FTW_HI   = 31;
  localparam int FTW_LO   = 0;
  localparam int STEP_HI  = 55;
  localparam int STEP_LO  = 40;
  localparam int END_HI   = 39;
  localparam int END_LO   = 30;
  localparam int START_HI = 23;
  localparam int START_LO = 14;
  localparam int MODE_HI  = 2;
  localparam int MODE_LO  = 0;
  localparam int ZERO_CROSS_BIT = 3;
  localparam int NO_DWELL_BIT   = 5;

  typedef enum logic [1:0] {SER_INSTR, SER_DATA, SER_SKIP} ddsr_ser_state_t;

  // byte depth per address, zero for slots with no register behind them
  function automatic logic [3:0] ddsr_reg_bytes(input logic [4:0] addr);
    logic [3:0] n;
    n = OTHER_BYTES;
    if (addr > ADDR_LAST || addr == ADDR_UNUSED_A || addr == ADDR_UNUSED_B) begin
      n = NO_BYTES;
    end else if (addr == ADDR_WAVE_WORD) begin
      n = WAVE_BYTES;
    end else if (addr >= ADDR_PROF_FIRST) begin
      n = PROF_BYTES;
    end else if (addr == ADDR_CTRL_ONE) begin
      n = CTRL_BYTES;
    end
    return n;
  endfunction

endpackage

// ---- src/ddsr_profile_decode.sv ----
// profile word field decoder: single-tone or ram playback view
`timescale 1ns/1ps
module ddsr_profile_decode
  import ddsr_pkg::*;
(
  input  wire logic [63:0] profWord,     // selected active profile word
  input  wire logic        ramMode,      // ram operation enabled
  output logic      [31:0] toneFtw,      // frequency tuning word
  output logic      [15:0] tonePow,      // phase offset word
  output logic      [13:0] toneAsf,      // amplitude scale factor
  output logic      [15:0] ramStep,      // address step rate
  output logic       [9:0] ramStart,     // waveform start address
  output logic       [9:0] ramEnd,       // waveform end address
  output logic       [2:0] ramModeCtl,   // playback mode control
  output logic             ramZeroCross, // zero-crossing flag
  output logic             ramNoDwell    // no-dwell high flag
);

  // ****************************************************************
  // field split
  // ****************************************************************
  // each group is one unsigned word, msb at the highest bit; the unused view reads zero
  always_comb begin
    toneFtw      = '0;
    tonePow      = '0;
    toneAsf      = '0;
    ramStep      = '0;
    ramStart     = '0;
    ramEnd       = '0;
    ramModeCtl   = '0;
    ramZeroCross = 1'b0;
    ramNoDwell   = 1'b0;
    if (ramMode) begin
      ramStep      = profWord[STEP_HI:STEP_LO];
      ramEnd       = profWord[END_HI:END_LO];
      ramStart     = profWord[START_HI:START_LO];
      ramModeCtl   = profWord[MODE_HI:MODE_LO];
      ramZeroCross = profWord[ZERO_CROSS_BIT];
      ramNoDwell   = profWord[NO_DWELL_BIT];
    end else begin
      toneFtw = profWord[FTW_HI:FTW_LO];
      tonePow = profWord[POW_HI:POW_LO];
      toneAsf = profWord[ASF_HI:ASF_LO];
    end
  end

endmodule // ddsr_profile_decode

// ---- src/ddsr_register_bank.sv ----
// serial register bank of the synthesizer with update-strobe double buffering
`timescale 1ns/1ps
module ddsr_register_bank
  import ddsr_pkg::*;
(
  input  wire logic        clk,          // system clock, 250 MHz
  input  wire logic        sys_rst,      // async reset, active high
  input  wire logic        serClk,       // serial clock, sampled
  input  wire logic        serCsN,       // serial chip select, active low
  input  wire logic        serDin,       // serial data in
  output logic             serDout,      // serial data out
  output logic             serDoutEn,    // serial data out enable
  input  wire logic        ioUpdate,     // update strobe pin
  input  wire logic  [2:0] profPins,     // profile select pins
  output logic      [31:0] ctrlOne,      // effective control function one
  output logic             ramEnable,    // ram operation enabled
  output logic       [2:0] profIdx,      // profile in use
  output logic      [31:0] toneFtw,      // frequency tuning word
  output logic      [15:0] tonePow,      // phase offset word
  output logic      [13:0] toneAsf,      // amplitude scale factor
  output logic      [15:0] ramStep,      // address step rate
  output logic       [9:0] ramStart,     // waveform start address
  output logic       [9:0] ramEnd,       // waveform end address
  output logic       [2:0] ramModeCtl,   // playback mode control
  output logic             ramZeroCross, // zero-crossing flag
  output logic             ramNoDwell,   // no-dwell high flag
  output logic      [31:0] waveWord      // active ram access word
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  ddsr_ser_state_t serState_q;
  logic            serClk_q;
  logic            ioUpdate_q;
  logic      [2:0] profPins_q;
  logic      [7:0] instr_q;
  logic      [6:0] bitCnt_q;
  logic      [4:0] addr_q;
  logic            read_q;
  logic      [3:0] len_q;
  logic     [63:0] shift_q;
  logic     [63:0] buf_q [NUM_SLOTS];
  logic     [63:0] act_q [NUM_SLOTS];
  logic            clkRise;
  logic            clkFall;
  logic      [7:0] instrNext;
  logic      [4:0] instrAddr;
  logic      [3:0] instrLen;
  logic      [6:0] lenBits;
  logic     [63:0] shiftNext;
  logic     [63:0] lenMask;
  logic            lastBit;
  logic            wrEn;
  logic     [63:0] wrData;
  logic            profChange;
  logic            updPulse;
  logic      [3:0] intProf;
  logic      [2:0] profSel;
  logic     [63:0] profWordSel;
  logic     [31:0] dToneFtw;
  logic     [15:0] dTonePow;
  logic     [13:0] dToneAsf;
  logic     [15:0] dRamStep;
  logic      [9:0] dRamStart;
  logic      [9:0] dRamEnd;
  logic      [2:0] dRamMode;
  logic            dRamZero;
  logic            dRamDwell;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****************************************************************
  // serial bit engine
  // ****************************************************************
  // edges of the sampled serial clock; inputs are synchronous to clk
  assign clkRise   = serClk && !serClk_q;
  assign clkFall   = !serClk && serClk_q;
  assign instrNext = {instr_q[6:0], serDin};
  assign instrAddr = instrNext[4:0];
  assign instrLen  = ddsr_reg_bytes(instrAddr);
  assign lenBits   = {len_q, 3'b000};
  assign shiftNext = {shift_q[62:0], serDin};
  assign lenMask   = (len_q == PROF_BYTES) ? {64{1'b1}} : {32'h0, {32{1'b1}}};
  // last data bit of the register's exact byte count
  assign lastBit   = clkRise && !serCsN && serState_q == SER_DATA
                     && bitCnt_q == lenBits - 7'h01;
  assign wrEn      = lastBit && !read_q;
  assign wrData    = shiftNext & lenMask;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serClk_q   <= 1'b0;
      ioUpdate_q <= 1'b0;
      profPins_q <= 3'h0;
    end else begin
      serClk_q   <= serClk;
      ioUpdate_q <= ioUpdate;
      profPins_q <= profPins;
    end
  end

  // frame sequencer: instruction byte, then exactly the register's bytes, then next instruction; a slot with no register skips to the end of the frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serState_q <= SER_INSTR;
      instr_q    <= 8'h00;
      bitCnt_q   <= 7'h00;
      addr_q     <= 5'h00;
      read_q     <= 1'b0;
      len_q      <= 4'h0;
      shift_q    <= 64'h0;
    end else if (serCsN) begin
      // a frame cut short loses its partial register; nothing is stored
      serState_q <= SER_INSTR;
      bitCnt_q   <= 7'h00;
    end else if (clkRise) begin
      case (serState_q)
        SER_INSTR: begin
          instr_q  <= instrNext;
          bitCnt_q <= bitCnt_q + 7'h01;
          if (bitCnt_q == INSTR_LAST_BIT) begin
            bitCnt_q <= 7'h00;
            addr_q   <= instrAddr;
            read_q   <= instrNext[INSTR_READ_BIT];
            len_q    <= instrLen;
            // read data leaves msb first, so left-align the register's bytes;
            // empty or out-of-range slots shift zeros, never an index past the array
            shift_q  <= (instrLen == NO_BYTES) ? 64'h0
                        : (instrLen == PROF_BYTES) ? buf_q[instrAddr]
                        : {buf_q[instrAddr][31:0], 32'h0};
            serState_q <= (instrLen == NO_BYTES) ? SER_SKIP : SER_DATA;
          end
        end
        SER_DATA: begin
          shift_q  <= shiftNext;
          bitCnt_q <= bitCnt_q + 7'h01;
          if (lastBit) begin
            bitCnt_q   <= 7'h00;
            serState_q <= SER_INSTR;
          end
        end
        default: begin
          // unused slot: clocks are swallowed until chip select rises
          serState_q <= SER_SKIP;
        end
      endcase
    end
  end

  // read data changes on the falling serial edge so the host samples it on the rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serDout <= 1'b0;
    end else if (clkFall) begin
      serDout <= shift_q[63];
    end
  end

  assign serDoutEn = !serCsN && read_q && serState_q == SER_DATA;

  // ****************************************************************
  // buffer and active registers
  // ****************************************************************
  assign profChange = profPins != profPins_q;
  assign updPulse   = (ioUpdate && !ioUpdate_q) || profChange;

  // writes only reach implemented slots, so 0x05 and 0x06 stay empty
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        buf_q[i] <= REG_RESET;
      end
    end else if (wrEn) begin
      buf_q[addr_q] <= wrData;
    end
  end

  // one active copy per slot, loaded from the buffer on an update
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : gActive
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        act_q[g] <= REG_RESET;
      end else if (updPulse) begin
        act_q[g] <= buf_q[g];
      end
    end
  end

  // ****************************************************************
  // profile selection and outputs
  // ****************************************************************
  // internal profile bits come straight from the buffer, bypassing the strobe
  assign intProf   = buf_q[ADDR_CTRL_ONE][INT_PROF_HI:INT_PROF_LO];
  assign ctrlOne   = {act_q[ADDR_CTRL_ONE][31:INT_PROF_HI+1], intProf,
                      act_q[ADDR_CTRL_ONE][INT_PROF_LO-1:0]};
  assign ramEnable = act_q[ADDR_CTRL_ONE][RAM_EN_BIT];
  // internal control is ignored while ram is off; zero hands control to the pins
  assign profSel   = (ramEnable && intProf != 4'h0) ? intProf[2:0] : profPins;
  assign profWordSel = act_q[ADDR_PROF_FIRST + {2'b00, profSel}];

  ddsr_profile_decode uDecode (
    .profWord     (profWordSel),
    .ramMode      (ramEnable),
    .toneFtw      (dToneFtw),
    .tonePow      (dTonePow),
    .toneAsf      (dToneAsf),
    .ramStep      (dRamStep),
    .ramStart     (dRamStart),
    .ramEnd       (dRamEnd),
    .ramModeCtl   (dRamMode),
    .ramZeroCross (dRamZero),
    .ramNoDwell   (dRamDwell)
  );

  // decoded fields registered so data outputs leave flip-flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      profIdx      <= 3'h0;
      toneFtw      <= 32'h0;
      tonePow      <= 16'h0;
      toneAsf      <= 14'h0;
      ramStep      <= 16'h0;
      ramStart     <= 10'h0;
      ramEnd       <= 10'h0;
      ramModeCtl   <= 3'h0;
      ramZeroCross <= 1'b0;
      ramNoDwell   <= 1'b0;
      waveWord     <= 32'h0;
    end else begin
      profIdx      <= profSel;
      toneFtw      <= dToneFtw;
      tonePow      <= dTonePow;
      toneAsf      <= dToneAsf;
      ramStep      <= dRamStep;
      ramStart     <= dRamStart;
      ramEnd       <= dRamEnd;
      ramModeCtl   <= dRamMode;
      ramZeroCross <= dRamZero;
      ramNoDwell   <= dRamDwell;
      waveWord     <= act_q[ADDR_WAVE_WORD][31:0];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence profWrite_s;
    wrEn && addr_q >= ADDR_PROF_FIRST && addr_q < ADDR_WAVE_WORD;
  endsequence

  sequence waveWrite_s;
    wrEn && addr_q == ADDR_WAVE_WORD;
  endsequence

  sequence ctrlWrite_s;
    wrEn && addr_q == ADDR_CTRL_ONE;
  endsequence

  unused_slot_a: assert property (buf_q[ADDR_UNUSED_A] == 64'h0
    && buf_q[ADDR_UNUSED_B] == 64'h0)
    else $error("unused slot holds data");

  write_range_a: assert property (wrEn |-> addr_q <= ADDR_LAST
    && addr_q != ADDR_UNUSED_A && addr_q != ADDR_UNUSED_B)
    else $error("write to a slot with no register");

  prof_length_a: assert property (profWrite_s |-> bitCnt_q == 7'd63)
    else $error("profile write not eight bytes");

  wave_length_a: assert property (waveWrite_s |-> bitCnt_q == 7'd31)
    else $error("ram word write not four bytes");

  hold_active_a: assert property (!updPulse |=> $stable(act_q[ADDR_PROF_SEVEN]))
    else $error("active profile changed without update");

  update_copy_a: assert property (updPulse |=>
    act_q[ADDR_PROF_SIX] == $past(buf_q[ADDR_PROF_SIX]))
    else $error("update did not copy buffer");

  int_prof_now_a: assert property (ctrlWrite_s |=>
    ctrlOne[INT_PROF_HI:INT_PROF_LO] == $past(wrData[INT_PROF_HI:INT_PROF_LO]))
    else $error("internal profile control not immediate");

  ram_start_a: assert property ($past(ramEnable) |->
    ramStart == $past(profWordSel[START_HI:START_LO]))
    else $error("start address field misplaced");

  mode_field_a: assert property ($past(ramEnable) |->
    ramModeCtl == $past(profWordSel[MODE_HI:MODE_LO])
    && ramNoDwell == $past(profWordSel[NO_DWELL_BIT]))
    else $error("mode or no-dwell field misplaced");

  tone_view_a: assert property (!$past(ramEnable) |-> ramStart == 10'h0
    && toneFtw == $past(profWordSel[FTW_HI:FTW_LO]))
    else $error("single-tone view wrong");

endmodule // ddsr_register_bank

// ---- sim/ddsr_host_model.sv ----
// host controller model that drives the serial port of the register bank
`timescale 1ns/1ps
module ddsr_host_model
  import ddsr_pkg::*;
(
  input  wire logic clk,       // system clock
  output logic      serClk,    // serial clock, still between frames
  output logic      serCsN,    // chip select, active low
  output logic      serDin,    // serial data to the bank
  input  wire logic serDout,   // serial read data
  input  wire logic serDoutEn  // read data enable
);
  // cycles per serial clock phase; raise it to act as a slow host
  int holdCyc = 2;

  initial begin
    serClk = 1'b0;
    serCsN = 1'b1;
    serDin = 1'b0;
  end

  // ****************************************************************
  // one serial bit
  // ****************************************************************
  // read data is taken on the falling clk edge, well clear of its update
  task automatic send_bit(input logic b, output logic r, output logic e);
    @(negedge clk);
    r = serDout;
    e = serDoutEn;
    @(posedge clk);
    serDin <= b;
    serClk <= 1'b1;
    repeat (holdCyc) @(posedge clk);
    serClk <= 1'b0;
    repeat (holdCyc) @(posedge clk);
  endtask

  // ****************************************************************
  // one register transfer: instruction byte, then nBits of data
  // ****************************************************************
  // keep leaves the frame open so the next instruction follows at once
  task automatic xfer(input logic rd, input logic [4:0] addr, input int nBytes,
                      input logic [63:0] wData, input int nBits, input logic keep,
                      output logic [63:0] rData, output logic enSeen);
    logic [7:0] instr;
    logic       b;
    logic       e;
    instr  = {rd, 2'b00, addr};
    rData  = '0;
    enSeen = 1'b0;
    @(posedge clk);
    serCsN <= 1'b0;
    for (int i = 7; i >= 0; i--) send_bit(instr[i], b, e);
    // data runs msb first over the register's own byte count
    for (int i = 0; i < nBits; i++) begin
      send_bit(wData[nBytes*8-1-i], b, e);
      rData[nBytes*8-1-i] = b;
      enSeen = enSeen | e;
    end
    // a released data line shows the inverse, never the last bit
    if (!keep) begin
      @(posedge clk);
      serCsN <= 1'b1;
      serDin <= ~serDin;
    end
  endtask
endmodule // ddsr_host_model

// ---- sim/testbench.sv ----
// self-checking testbench of the serial register bank
`timescale 1ns/1ps
module testbench;
  import ddsr_pkg::*;
  logic        clk, sys_rst, serClk, serCsN, serDin, serDout, serDoutEn, ioUpdate;
  logic  [2:0] profPins, profIdx, ramModeCtl;
  logic [31:0] ctrlOne, toneFtw, waveWord;
  logic [15:0] tonePow, ramStep;
  logic [13:0] toneAsf;
  logic  [9:0] ramStart, ramEnd;
  logic        ramEnable, ramZeroCross, ramNoDwell, e;
  logic [63:0] r, tw, rw;
  int          n_errors = 0;
  int          num_checks = 0;

  ddsr_register_bank dut_u (.clk(clk), .sys_rst(sys_rst), .serClk(serClk),
    .serCsN(serCsN), .serDin(serDin), .serDout(serDout), .serDoutEn(serDoutEn),
    .ioUpdate(ioUpdate), .profPins(profPins), .ctrlOne(ctrlOne), .ramEnable(ramEnable),
    .profIdx(profIdx), .toneFtw(toneFtw), .tonePow(tonePow), .toneAsf(toneAsf),
    .ramStep(ramStep), .ramStart(ramStart), .ramEnd(ramEnd), .ramModeCtl(ramModeCtl),
    .ramZeroCross(ramZeroCross), .ramNoDwell(ramNoDwell), .waveWord(waveWord));
  ddsr_host_model host_u (.clk(clk), .serClk(serClk), .serCsN(serCsN),
    .serDin(serDin), .serDout(serDout), .serDoutEn(serDoutEn));

  // 250 MHz system clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input int n, input logic [63:0] d);
    host_u.xfer(1'b0, a, n, d, n * 8, 1'b0, r, e);
  endtask

  task automatic rd(input logic [4:0] a, input int n);
    host_u.xfer(1'b1, a, n, 64'h0, n * 8, 1'b0, r, e);
  endtask

  // lets every registered output land before it is looked at
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic upd();
    @(posedge clk);
    ioUpdate <= 1'b1;
    @(posedge clk);
    ioUpdate <= 1'b0;
    settle();
  endtask

  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    sys_rst  = 1'b1;
    ioUpdate = 1'b0;
    profPins = 3'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    // reset state
    chk(ctrlOne, 64'h0, "ctrl reset");
    chk(waveWord, 64'h0, "wave reset");
    rd(ADDR_PROF_SEVEN, int'(PROF_BYTES));
    chk(r, REG_RESET, "profile reset");
    $display("test reset done");
    // wave word held in buffer until the strobe, read by a slow host
    wr(ADDR_WAVE_WORD, int'(WAVE_BYTES), 64'hc3a5_5a3c);
    settle();
    chk(waveWord, 64'h0, "wave before strobe");
    upd();
    chk(waveWord, 64'hc3a5_5a3c, "wave after strobe");
    host_u.holdCyc = 5;
    rd(ADDR_WAVE_WORD, int'(WAVE_BYTES));
    host_u.holdCyc = 2;
    chk(r, 64'hc3a5_5a3c, "wave readback");
    $display("test buffer done");
    // unused slots, out of range address and an aborted write
    wr(ADDR_UNUSED_A, 4, 64'hffff_ffff);
    rd(ADDR_UNUSED_A, 4);
    chk(e, 1'b0, "unused a read enable");
    rd(ADDR_UNUSED_B, 4);
    chk(e, 1'b0, "unused b read enable");
    wr(5'h17, 4, 64'h0bad_f00d);
    host_u.xfer(1'b0, ADDR_WAVE_WORD, 4, 64'h1111_2222, 12, 1'b0, r, e);
    rd(ADDR_WAVE_WORD, int'(WAVE_BYTES));
    chk(r, 64'hc3a5_5a3c, "wave after refusals");
    upd();
    chk(waveWord, 64'hc3a5_5a3c, "wave active after abort");
    $display("test refusal done");
    // back-to-back profile writes in one frame, single-tone view
    tw = '0;
    tw[ASF_HI:ASF_LO] = 14'h1abc;
    tw[POW_HI:POW_LO] = 16'h8421;
    tw[FTW_HI:FTW_LO] = 32'h8765_4321;
    rw = '0;
    rw[STEP_HI:STEP_LO] = 16'h1234;
    rw[END_HI:END_LO] = 10'h2ab;
    rw[START_HI:START_LO] = 10'h155;
    rw[MODE_HI:MODE_LO] = 3'h5;
    rw[ZERO_CROSS_BIT] = 1'b1;
    rw[NO_DWELL_BIT] = 1'b1;
    host_u.xfer(1'b0, ADDR_PROF_SIX, 8, rw, 64, 1'b1, r, e);
    host_u.xfer(1'b0, ADDR_PROF_SEVEN, 8, tw, 64, 1'b0, r, e);
    rd(ADDR_PROF_SIX, int'(PROF_BYTES));
    chk(r, rw, "profile six readback");
    @(posedge clk);
    profPins <= 3'h7;
    settle();
    chk(profIdx, 3'h7, "pin profile");
    chk(toneFtw, 32'h8765_4321, "tone ftw");
    chk(tonePow, 16'h8421, "tone pow");
    chk(toneAsf, 14'h1abc, "tone asf");
    chk(ramStep, 16'h0, "ram view off");
    $display("test single tone done");
    // ram mode: same word read as a ram playback profile
    wr(ADDR_CTRL_ONE, int'(CTRL_BYTES), 64'h8000_0000);
    upd();
    chk(ramEnable, 1'b1, "ram enable");
    chk(toneFtw, 32'h0, "tone view off");
    chk(ramStart, tw[START_HI:START_LO], "profile seven as ram");
    chk(ramModeCtl, tw[MODE_HI:MODE_LO], "profile seven mode");
    chk({ramNoDwell, ramZeroCross}, {tw[NO_DWELL_BIT], tw[ZERO_CROSS_BIT]}, "seven flags");
    @(posedge clk);
    profPins <= 3'h6;
    settle();
    chk(ramStart, 10'h155, "ram start");
    chk(ramEnd, 10'h2ab, "ram end");
    chk(ramStep, 16'h1234, "ram step");
    chk(ramModeCtl, 3'h5, "ram mode");
    chk({ramNoDwell, ramZeroCross}, 2'h3, "ram flags");
    $display("test ram profile done");
    // internal profile field acts at once, other bits wait for the strobe
    wr(ADDR_CTRL_ONE, int'(CTRL_BYTES), 64'h804e_0000);
    settle();
    chk(ctrlOne[INT_PROF_HI:INT_PROF_LO], 4'h7, "internal profile at once");
    chk(ctrlOne[22], 1'b0, "other bit buffered");
    upd();
    chk(ctrlOne, 32'h804e_0000, "ctrl after strobe");
    chk(profIdx, 3'h7, "internal profile used");
    wr(ADDR_CTRL_ONE, int'(CTRL_BYTES), 64'h000e_0000);
    upd();
    chk(profIdx, 3'h6, "internal profile needs ram");
    $display("test internal profile done");
    wrap_up();
  end
endmodule // testbench
